//--- core/frr_pkg.sv
// shared constants and types for the flash reset and recovery block
package frr_pkg;

	// clock rate of clock_i
	localparam int unsigned CLK_MHZ = 50;

	// times as printed, in their own units
	localparam int unsigned RESET_LOW_WIDTH_US = 10;
	localparam int unsigned RESET_TO_SELECT_DELAY_US = 10;
	localparam int unsigned RESET_RECOVERY_POWERON_US = 35;
	localparam int unsigned RECOVERY_DECODE_US = 40;
	localparam int unsigned RECOVERY_READ_US = 35;
	localparam int unsigned RECOVERY_PROGRAM_US = 310;
	localparam int unsigned RECOVERY_SECTOR_MS = 12;
	localparam int unsigned RECOVERY_BLOCK_MS = 25;
	localparam int unsigned RECOVERY_CHIP_MS = 100;
	localparam int unsigned RECOVERY_STATUS_MS = 40;

	// least times as whole cycles (exact at 50 MHz, so no rounding is lost)
	localparam int unsigned RESET_LOW_WIDTH_CYC = RESET_LOW_WIDTH_US * CLK_MHZ;
	localparam int unsigned RESET_TO_SELECT_DELAY_CYC = RESET_TO_SELECT_DELAY_US * CLK_MHZ;
	localparam int unsigned RESET_RECOVERY_POWERON_CYC = RESET_RECOVERY_POWERON_US * CLK_MHZ;
	localparam int unsigned RECOVERY_DECODE_CYC = RECOVERY_DECODE_US * CLK_MHZ;
	localparam int unsigned RECOVERY_READ_CYC = RECOVERY_READ_US * CLK_MHZ;
	localparam int unsigned RECOVERY_PROGRAM_CYC = RECOVERY_PROGRAM_US * CLK_MHZ;
	localparam int unsigned RECOVERY_SECTOR_CYC = RECOVERY_SECTOR_MS * 1000 * CLK_MHZ;
	localparam int unsigned RECOVERY_BLOCK_CYC = RECOVERY_BLOCK_MS * 1000 * CLK_MHZ;
	localparam int unsigned RECOVERY_CHIP_CYC = RECOVERY_CHIP_MS * 1000 * CLK_MHZ;
	localparam int unsigned RECOVERY_STATUS_CYC = RECOVERY_STATUS_MS * 1000 * CLK_MHZ;

	// software reset opcodes
	localparam logic [7:0] OPC_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OPC_RESET = 8'h99;

	// register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_LOCK = 4'h8;
	localparam logic [3:0] REG_COUNT = 4'hc;

	// control register fields
	localparam int unsigned CTRL_KIND_LSB = 0;
	localparam int unsigned CTRL_WRITE_ENABLE_LATCH_BIT = 4;
	localparam int unsigned CTRL_ADDR4_BIT = 5;
	localparam int unsigned CTRL_START_BIT = 8;

	// values after reset
	localparam logic RST_WRITE_ENABLE_LATCH = 1'b0;
	localparam logic RST_WRITE_IN_PROGRESS = 1'b0;
	localparam logic RST_ADDR4 = 1'b0;
	localparam logic RST_LOCK_BIT = 1'b1;

	// operation that may be interrupted by a reset
	typedef enum logic [2:0] {
		OP_NONE,
		OP_READ,
		OP_PROGRAM,
		OP_SECTOR,
		OP_BLOCK,
		OP_CHIP,
		OP_STATUS
	} frr_op_e;

	// decoded command byte from the serial front end
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
	} frr_cmd_s;

	// status word as software reads it
	typedef struct packed {
		logic [21:0] zero;
		logic [2:0] op;
		logic reset_enabled;
		logic pin_reset;
		logic recovering;
		logic ready;
		logic addr4;
		logic write_enable_latch;
		logic write_in_progress;
	} frr_status_s;

endpackage : frr_pkg

//--- core/frr_top.sv
// reset sequencer: hardware pin reset, two-step software reset, recovery timing
`timescale 1ns/1ps
`default_nettype none

module frr_top #(
	parameter int unsigned LOCK_BITS = 16,
	parameter int unsigned PROGRAM_CYC = frr_pkg::RECOVERY_PROGRAM_CYC,
	parameter int unsigned SECTOR_CYC = frr_pkg::RECOVERY_SECTOR_CYC,
	parameter int unsigned BLOCK_CYC = frr_pkg::RECOVERY_BLOCK_CYC,
	parameter int unsigned CHIP_CYC = frr_pkg::RECOVERY_CHIP_CYC,
	parameter int unsigned STATUS_CYC = frr_pkg::RECOVERY_STATUS_CYC
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic reset_n_i,
	input wire frr_pkg::frr_cmd_s cmd_i,
	input wire logic op_done_i,
	input wire logic so_drive_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic so_oe_o,
	output logic cmd_accept_o,
	output logic abort_o,
	output logic ready_o,
	output logic addr4_o,
	output logic write_enable_latch_o,
	output logic write_in_progress_o,
	output logic [LOCK_BITS-1:0] lock_o
);

	typedef enum logic [1:0] {
		ST_READY,
		ST_PIN_HELD,
		ST_RECOVER
	} frr_state_e;

	frr_state_e state_q;
	frr_pkg::frr_op_e op_q;
	frr_pkg::frr_op_e held_op_q;
	logic [31:0] count_q;
	logic reset_en_q;
	logic write_enable_latch_q;
	logic write_in_progress_q;
	logic addr4_q;
	logic [LOCK_BITS-1:0] lock_q;
	logic sw_reset;
	logic pin_low;
	logic do_reset;
	logic cmd_ok;
	logic ctrl_wr;
	frr_pkg::frr_op_e wr_kind;
	logic [31:0] recover_cyc;
	frr_pkg::frr_status_s status;

	// commands and writes only count while the device is idle and the pin is high
	// commands gated
	assign cmd_ok = cmd_i.valid && state_q == ST_READY && reset_n_i;
	assign pin_low = !reset_n_i;
	assign sw_reset = cmd_ok && reset_en_q && cmd_i.opcode == frr_pkg::OPC_RESET;
	assign do_reset = sw_reset || (pin_low && state_q != ST_PIN_HELD);
	assign ctrl_wr = wr_i && addr_i == frr_pkg::REG_CTRL && state_q == ST_READY && reset_n_i;
	assign wr_kind = frr_pkg::frr_op_e'(wdata_i[frr_pkg::CTRL_KIND_LSB +: 3]);

	// recovery length chosen by what was interrupted, never below the select delay
	always_comb begin
		case (state_q == ST_PIN_HELD ? held_op_q : op_q)
			frr_pkg::OP_NONE: recover_cyc = frr_pkg::RECOVERY_DECODE_CYC;
			frr_pkg::OP_READ: recover_cyc = frr_pkg::RECOVERY_READ_CYC;
			frr_pkg::OP_PROGRAM: recover_cyc = PROGRAM_CYC;
			frr_pkg::OP_SECTOR: recover_cyc = SECTOR_CYC;
			frr_pkg::OP_BLOCK: recover_cyc = BLOCK_CYC;
			frr_pkg::OP_CHIP: recover_cyc = CHIP_CYC;
			frr_pkg::OP_STATUS: recover_cyc = STATUS_CYC;
			default: recover_cyc = frr_pkg::RECOVERY_DECODE_CYC;
		endcase
		if (recover_cyc < frr_pkg::RESET_TO_SELECT_DELAY_CYC) begin
			recover_cyc = frr_pkg::RESET_TO_SELECT_DELAY_CYC;
		end
	end

	// sequencer: pin held, then counted recovery, then ready
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= ST_RECOVER;
			count_q <= frr_pkg::RESET_RECOVERY_POWERON_CYC - 1;
			held_op_q <= frr_pkg::OP_NONE;
		end else if (pin_low) begin
			// the pin wins over everything but rst_i, including a recovery already running
			state_q <= ST_PIN_HELD;
			if (state_q != ST_PIN_HELD) begin
				held_op_q <= op_q;
			end
		end else if (state_q == ST_PIN_HELD) begin
			state_q <= ST_RECOVER;
			count_q <= recover_cyc - 1;
		end else if (sw_reset) begin
			state_q <= ST_RECOVER;
			count_q <= recover_cyc - 1;
		end else if (state_q == ST_RECOVER) begin
			if (count_q == 32'h0000_0000) begin
				state_q <= ST_READY;
			end else begin
				count_q <= count_q - 32'h0000_0001;
			end
		end
	end

	// pending software reset: armed by 66h, cleared by any other command
	always_ff @(posedge clock_i) begin
		if (rst_i || do_reset) begin
			reset_en_q <= 1'b0;
		end else if (cmd_ok) begin
			reset_en_q <= cmd_i.opcode == frr_pkg::OPC_RESET_ENABLE;
		end
	end

	// operation tracking; a reset drops whatever was running
	always_ff @(posedge clock_i) begin
		if (rst_i || do_reset) begin
			op_q <= frr_pkg::OP_NONE;
			write_in_progress_q <= frr_pkg::RST_WRITE_IN_PROGRESS;
		end else if (ctrl_wr && wdata_i[frr_pkg::CTRL_START_BIT]) begin
			op_q <= wr_kind;
			write_in_progress_q <= wr_kind != frr_pkg::OP_NONE && wr_kind != frr_pkg::OP_READ;
		end else if (op_done_i && op_q != frr_pkg::OP_NONE) begin
			op_q <= frr_pkg::OP_NONE;
			write_in_progress_q <= 1'b0;
		end
	end

	// volatile bits: write latch, address mode, lock bits
	always_ff @(posedge clock_i) begin
		if (rst_i || do_reset) begin
			write_enable_latch_q <= frr_pkg::RST_WRITE_ENABLE_LATCH;
			lock_q <= {LOCK_BITS{frr_pkg::RST_LOCK_BIT}};
			addr4_q <= frr_pkg::RST_ADDR4;
		end else if (ctrl_wr) begin
			write_enable_latch_q <= wdata_i[frr_pkg::CTRL_WRITE_ENABLE_LATCH_BIT];
			addr4_q <= wdata_i[frr_pkg::CTRL_ADDR4_BIT];
		end else if (wr_i && addr_i == frr_pkg::REG_LOCK && state_q == ST_READY && reset_n_i) begin
			lock_q <= wdata_i[LOCK_BITS-1:0];
		end else if (op_done_i && write_in_progress_q) begin
			// a finished write operation drops the latch
			write_enable_latch_q <= 1'b0;
		end
	end

	assign status = '{
		zero: '0,
		op: op_q,
		reset_enabled: reset_en_q,
		pin_reset: state_q == ST_PIN_HELD,
		recovering: state_q == ST_RECOVER,
		ready: state_q == ST_READY,
		addr4: addr4_q,
		write_enable_latch: write_enable_latch_q,
		write_in_progress: write_in_progress_q
	};

	// read data, valid the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			case (addr_i)
				frr_pkg::REG_CTRL: rdata_o <= {23'h00_0000, 1'b0, 2'b00, addr4_q,
					write_enable_latch_q, 1'b0, op_q};
				frr_pkg::REG_STATUS: rdata_o <= status;
				frr_pkg::REG_LOCK: rdata_o <= 32'(lock_q);
				frr_pkg::REG_COUNT: rdata_o <= state_q == ST_RECOVER ? count_q : 32'h0000_0000;
				default: rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	// registered outputs; the output enable is cut at once when the pin drops
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			so_oe_o <= 1'b0;
			cmd_accept_o <= 1'b0;
			abort_o <= 1'b0;
			ready_o <= 1'b0;
		end else begin
			so_oe_o <= so_drive_i && state_q == ST_READY && reset_n_i && !sw_reset;
			cmd_accept_o <= state_q == ST_READY && reset_n_i && !sw_reset;
			abort_o <= do_reset && write_in_progress_q;
			ready_o <= state_q == ST_READY && reset_n_i && !sw_reset;
		end
	end

	// mirrors of the volatile state
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			addr4_o <= frr_pkg::RST_ADDR4;
			write_enable_latch_o <= frr_pkg::RST_WRITE_ENABLE_LATCH;
			write_in_progress_o <= frr_pkg::RST_WRITE_IN_PROGRESS;
			lock_o <= {LOCK_BITS{frr_pkg::RST_LOCK_BIT}};
		end else begin
			addr4_o <= addr4_q;
			write_enable_latch_o <= write_enable_latch_q;
			write_in_progress_o <= write_in_progress_q;
			lock_o <= lock_q;
		end
	end

endmodule : frr_top

`default_nettype wire

//--- tb/frr_chk.sv
// port assertions for the flash reset sequencer
`timescale 1ns/1ps
`default_nettype none
module frr_chk #(
	parameter int unsigned LOCK_BITS = 16
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic reset_n_i,
	input wire frr_pkg::frr_cmd_s cmd_i,
	input wire logic ready_o,
	input wire logic so_oe_o,
	input wire logic abort_o,
	input wire logic addr4_o,
	input wire logic write_enable_latch_o,
	input wire logic write_in_progress_o,
	input wire logic [LOCK_BITS-1:0] lock_o
);
	logic armed_q;
	logic take;
	logic [9:0] rel_q;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// a byte counts only in standby with the pin high
	assign take = cmd_i.valid && ready_o && reset_n_i;
	// remembers a taken 66h; any other taken byte disarms
	always_ff @(posedge clock_i) begin
		if (rst_i || !reset_n_i || !ready_o) begin
			armed_q <= 1'b0;
		end else if (take) begin
			armed_q <= cmd_i.opcode == frr_pkg::OPC_RESET_ENABLE;
		end
	end
	// cycles since pin release, saturating so it never wraps
	always_ff @(posedge clock_i) begin
		if (rst_i || !reset_n_i) begin
			rel_q <= '0;
		end else if (rel_q != 10'h3ff) begin
			rel_q <= rel_q + 10'h001;
		end
	end
	pin_hold_a: assert property (!reset_n_i ##1 !reset_n_i |=> !ready_o)
		else $error("ready while pin low");
	pin_bits_a: assert property (!reset_n_i ##1 !reset_n_i |=>
		!write_enable_latch_o && !write_in_progress_o && &lock_o)
		else $error("volatile bits kept");
	pin_addr_a: assert property (!reset_n_i ##1 !reset_n_i |=> !addr4_o)
		else $error("four byte mode kept");
	pin_float_a: assert property (!reset_n_i ##1 !reset_n_i |=> !so_oe_o)
		else $error("output driven in reset");
	// the mirrored bits trail the internal clear by one edge, ready drops at once
	sw_reset_a: assert property (take && armed_q && cmd_i.opcode == frr_pkg::OPC_RESET
		|=> !ready_o ##1 (!ready_o && !addr4_o && !write_enable_latch_o && !write_in_progress_o))
		else $error("no soft reset");
	sw_refuse_a: assert property (take && !armed_q && cmd_i.opcode == frr_pkg::OPC_RESET
		|=> ready_o) else $error("unarmed soft reset");
	op_abort_a: assert property ($fell(reset_n_i) && write_in_progress_o |-> ##[1:2] abort_o)
		else $error("no abort");
	por_hold_a: assert property ($fell(rst_i) |-> !ready_o [*8])
		else $error("ready during power on");
	early_rdy_a: assert property ($rose(ready_o) |-> rel_q >= 10'h1f4)
		else $error("ready too soon");
	sw_c: cover property (take && armed_q && cmd_i.opcode == frr_pkg::OPC_RESET);
	abort_c: cover property (abort_o);
	ready_c: cover property ($rose(ready_o));
endmodule : frr_chk
bind frr_top frr_chk #(.LOCK_BITS(LOCK_BITS)) u_chk (.clock_i, .rst_i, .reset_n_i, .cmd_i,
	.ready_o, .so_oe_o, .abort_o, .addr4_o, .write_enable_latch_o, .write_in_progress_o,
	.lock_o);
`default_nettype wire

//--- tb/frr_host.sv
// host controller model: reset pin and command bytes
`timescale 1ns/1ps
`default_nettype none
module frr_host (
	input wire logic clock_i,
	output logic reset_n_o,
	output var frr_pkg::frr_cmd_s cmd_o
);
	// idle pin high, no command
	initial begin
		reset_n_o = 1'b1;
		cmd_o = '{valid: 1'b0, opcode: 8'h5a};
	end
	// one byte pulse; opcode lines flip when idle so nothing stale looks valid
	task automatic send(input logic [7:0] op);
		@(posedge clock_i);
		cmd_o <= '{valid: 1'b1, opcode: op};
		@(posedge clock_i);
		cmd_o <= '{valid: 1'b0, opcode: ~op};
	endtask : send
	// pin reset, then the quiet time before any select
	task automatic pin_reset();
		@(posedge clock_i);
		reset_n_o <= 1'b0;
		repeat (frr_pkg::RESET_LOW_WIDTH_CYC) @(posedge clock_i);
		reset_n_o <= 1'b1;
		repeat (frr_pkg::RESET_TO_SELECT_DELAY_CYC) @(posedge clock_i);
	endtask : pin_reset
endmodule : frr_host
`default_nettype wire

//--- tb/flash_reset_recovery_tb.sv
// self-checking bench for the flash reset sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_reset_recovery_tb;
	localparam int PRG = 600, SEC = 700, BLK = 800, CHP = 900, STA = 1000;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic reset_n, wr = 1'b0, rd = 1'b0, ab = 1'b0;
	frr_pkg::frr_cmd_s cmd;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'h0000_a079;
	logic so_oe, abort, ready, a4, latch, busy, acc;
	logic [15:0] lock;
	int num_errors = 0, comparisons = 0, cyc = 0;
	// recovery per interrupted kind: decode, read, program, sector, block, chip, status
	int rec[7] = '{frr_pkg::RECOVERY_DECODE_CYC, frr_pkg::RECOVERY_READ_CYC, PRG, SEC, BLK,
		CHP, STA};
	frr_host host (.clock_i(clock_i), .reset_n_o(reset_n), .cmd_o(cmd));
	frr_top #(.PROGRAM_CYC(PRG), .SECTOR_CYC(SEC), .BLOCK_CYC(BLK), .CHIP_CYC(CHP),
		.STATUS_CYC(STA)) DUT (.clock_i(clock_i), .rst_i(rst_i), .reset_n_i(reset_n),
		.cmd_i(cmd), .op_done_i(1'b0), .so_drive_i(1'b1), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .so_oe_o(so_oe), .cmd_accept_o(acc),
		.abort_o(abort), .ready_o(ready), .addr4_o(a4), .write_enable_latch_o(latch),
		.write_in_progress_o(busy), .lock_o(lock));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic summarize();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	// bounded wait for standby, counting edges
	task automatic wait_ready(output int n);
		n = 0;
		#1;
		while (ready !== 1'b1 && n < 6000) begin
			@(posedge clock_i);
			#1 n++;
		end
	endtask : wait_ready
	always #10 clock_i = ~clock_i;
	// cycle ceiling and abort pulse catcher
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (abort === 1'b1) ab <= 1'b1;
		if (cyc == 60000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		int n;
		logic [31:0] d;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		wait_ready(n);
		chk("por", 1, n + 2 >= frr_pkg::RESET_RECOVERY_POWERON_CYC);
		rd_reg(4'h2, d);
		chk("unmapped", 0, d);
		for (int k = 0; k < 7; k++) begin
			seed = lfsr(seed);
			wr_reg(frr_pkg::REG_LOCK, seed);
			rd_reg(frr_pkg::REG_LOCK, d);
			chk("lock", seed[15:0], d);
			// start kind k with write latch and four byte mode set
			wr_reg(frr_pkg::REG_CTRL, 32'h0000_0130 | k);
			// output mirrors show the write one edge after it lands
			@(posedge clock_i);
			#1 chk("ctrl", {2'b11, k > 1}, {a4, latch, busy});
			ab = 1'b0;
			fork
				host.pin_reset();
				begin
					repeat (20) @(posedge clock_i);
					#1 chk("oe", 0, so_oe);
					chk("bits", 0, {a4, latch, busy});
					chk("lockdef", 16'hffff, lock);
					host.send(frr_pkg::OPC_RESET_ENABLE);
				end
			join
			chk("abort", k > 1, ab);
			wait_ready(n);
			chk("recovery", 1, n + 502 >= rec[k] && n + 497 <= rec[k]);
			host.send(frr_pkg::OPC_RESET);
			#1 chk("stale", 3'b111, {ready, acc, so_oe});
			wr_reg(frr_pkg::REG_CTRL, 32'h0000_0030);
			host.send(frr_pkg::OPC_RESET_ENABLE);
			host.send(8'h30 + 8'(k));
			host.send(frr_pkg::OPC_RESET);
			#1 chk("cancel", 1, ready);
			host.send(frr_pkg::OPC_RESET_ENABLE);
			host.send(frr_pkg::OPC_RESET);
			// ready falls at once, the mirrored bits one edge later
			@(posedge clock_i);
			#1 chk("soft", 0, {ready, acc, a4, latch, busy});
			wait_ready(n);
			chk("softrec", 1, n + 4 >= rec[0] && n <= rec[0] + 2);
		end
		summarize();
	end
endmodule : flash_reset_recovery_tb
`default_nettype wire
